// [rtl/ishp_host.sv]
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) data changes only while clock low
// (RL2) start/stop are data edges, clock high
// (RL3) master issues start/stop; Sr equals S
// (RL4) bytes msb first, then acknowledge bit
// (RL5) receiver holds ack low; transmitter releases
// (RL6) master nacks last read byte
// (RL7) first byte: address plus direction bit
// (RL8) device latches address pins at reset
// (RL9) mode low: fixed prefix plus three pins
// (RL10) mode high: six pins, top bit zero
// (RL11) write: address, register, data bytes
// (RL12) read preceded by register-only write frame
// (RL13) reads repeat same register, no increment
// (RL14) high speed after S, 00001xxx, nack
// (RL15) Sr then address; stop ends high speed
// (RL16) device starts in fast mode
// (RL17) forced high speed needs no master code
// (RL18) without master code stays fast mode
// (RL19) device acts only as slave
// (RL20) device filters clock and data spikes; model filters only start/stop edges on data
// (RL21) data only pulled low or released
// (RL22) device ignores bus after address mismatch
module ishp_host (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   // user command port
   input  wire ishp_pkg::ishp_cmd_t  cmd,
   input  wire logic                 cmd_valid,
   input  wire logic                 cmd_last,
   input  wire logic                 use_hs,
   output logic                      cmd_ready,
   output ishp_pkg::ishp_rsp_t       rsp,
   output logic                      rsp_valid,
   output logic                      hs_active,
   // bus pins, enables active low
   input  wire logic                 scl_i,
   output logic                      scl_o,
   output logic                      scl_oe_n,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe_n
);
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_START = 4'b0001,
      ST_BIT   = 4'b0010,
      ST_ACK   = 4'b0011,
      ST_NEXT  = 4'b0100,
      ST_STOP  = 4'b0101,
      ST_RSTRT = 4'b0110,
      ST_WAIT  = 4'b0111
   } ishp_state_t;
   typedef enum logic [2:0] {
      PH_MC  = 3'b000,
      PH_AW  = 3'b001,
      PH_REG = 3'b010,
      PH_DAT = 3'b011,
      PH_AR  = 3'b100,
      PH_RD  = 3'b101
   } ishp_phase_t;
   // ==========================================================
   // quarter-bit enable from divider
   logic [7:0]  div_r;
   logic        hs_r;
   wire  [7:0]  div_max = hs_r ? 8'(ishp_pkg::HS_QUARTER_CYCLES - 1) : 8'(ishp_pkg::QUARTER_CYCLES - 1);
   wire         tick    = (div_r == div_max);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) div_r <= 8'h00;
      else div_r <= tick ? 8'h00 : div_r + 8'h01;
   end
   // ==========================================================
   // pin synchronisers
   logic [1:0] sda_s_r;
   logic [1:0] scl_s_r;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sda_s_r <= 2'b11;
         scl_s_r <= 2'b11;
      end else begin
         sda_s_r <= {sda_s_r[0], sda_i};
         scl_s_r <= {scl_s_r[0], scl_i};
      end
   end
   wire sda_in = sda_s_r[1];
   wire scl_in = scl_s_r[1];
   // ==========================================================
   // byte engine
   ishp_state_t st_r;
   ishp_phase_t ph_r;
   logic [1:0]  q_r;
   logic [2:0]  bit_r;
   logic [7:0]  sh_r;
   logic        scl_r;
   logic        sda_r;
   logic        ack_r;
   logic        last_r;
   ishp_pkg::ishp_cmd_t c_r;
   wire         rx_phase = (ph_r == PH_RD);
   // clock stretching by the slave holds the quarter counter
   wire         stretch  = scl_r && !scl_in;
   wire         step     = tick && !stretch;
   wire         hs_rd    = (ph_r == PH_MC);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= ST_IDLE; ph_r <= PH_AW; q_r <= 2'd0; bit_r <= 3'd7; sh_r <= 8'h00;
         scl_r <= 1'b1; sda_r <= 1'b1; ack_r <= 1'b0; last_r <= 1'b0; c_r <= '0;
         hs_r <= 1'b0; cmd_ready <= 1'b0; rsp <= '0; rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         cmd_ready <= 1'b0;
         if (st_r == ST_IDLE) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            if (cmd_valid && !cmd_ready) begin
               c_r <= cmd; last_r <= cmd_last; cmd_ready <= 1'b1;
               ph_r <= use_hs ? PH_MC : PH_AW; // see (RL14)
               st_r <= ST_START; q_r <= 2'd0;
            end
         end else if (step) begin
            q_r <= q_r + 2'd1;
            unique case (st_r)
               ST_START, ST_RSTRT: begin   // see (RL2) (RL3)
                  unique case (q_r)
                     2'd0: begin sda_r <= 1'b1; end
                     2'd1: begin scl_r <= 1'b1; end
                     2'd2: begin sda_r <= 1'b0; end
                     default: begin
                        scl_r <= 1'b0; st_r <= ST_BIT; bit_r <= 3'd7;
                        unique case (ph_r)
                           PH_MC:  sh_r <= ishp_pkg::MASTER_CODE;
                           PH_AR:  sh_r <= {c_r.dev_addr, ishp_pkg::DIR_READ};   // see (RL7)
                           default: sh_r <= {c_r.dev_addr, ishp_pkg::DIR_WRITE};
                        endcase
                     end
                  endcase
               end
               ST_BIT, ST_ACK: begin
                  unique case (q_r)
                     2'd0: begin  // data moves only with clock low, see (RL1)
                        if (st_r == ST_BIT) sda_r <= rx_phase ? 1'b1 : sh_r[7]; // see (RL4)
                        else sda_r <= rx_phase ? last_r : 1'b1;                   // see (RL5) (RL6)
                     end
                     2'd1: scl_r <= 1'b1;
                     2'd2: begin
                        if (st_r == ST_BIT) sh_r <= {sh_r[6:0], sda_in};
                        else ack_r <= sda_in;
                     end
                     default: begin
                        scl_r <= 1'b0;
                        if (st_r == ST_ACK) st_r <= ST_NEXT;
                        else if (bit_r == 3'd0) st_r <= ST_ACK;
                        else bit_r <= bit_r - 3'd1;
                     end
                  endcase
               end
               ST_NEXT: begin
                  q_r <= 2'd0; bit_r <= 3'd7;
                  if (hs_rd) begin  // master code nack expected, see (RL14) (RL15)
                     hs_r <= 1'b1; ph_r <= PH_AW; st_r <= ST_RSTRT;
                  end else if (ack_r && !rx_phase) begin
                     rsp <= '{nack: 1'b1, rdata: 8'h00}; rsp_valid <= 1'b1; st_r <= ST_STOP;
                  end else begin
                     unique case (ph_r)
                        PH_AW:  begin ph_r <= PH_REG; sh_r <= c_r.reg_addr; st_r <= ST_BIT; end
                        PH_REG: begin  // read: register-only frame then Sr, see (RL12) (RL11)
                           if (c_r.is_read) begin ph_r <= PH_AR; st_r <= ST_RSTRT; end
                           else begin ph_r <= PH_DAT; sh_r <= c_r.wdata; st_r <= ST_BIT; end
                        end
                        PH_AR:  begin ph_r <= PH_RD; st_r <= ST_BIT; end
                        default: begin
                           if (rx_phase) rsp <= '{nack: 1'b0, rdata: sh_r};
                           else rsp <= '{nack: 1'b0, rdata: 8'h00};
                           rsp_valid <= 1'b1;
                           // one response per byte; the next byte is awaited in its own state
                           if (last_r) st_r <= ST_STOP;
                           else st_r <= ST_WAIT;
                        end
                     endcase
                  end
               end
               ST_WAIT: begin  // same register repeats, see (RL13)
                  q_r <= 2'd0;
                  if (cmd_valid) begin
                     c_r.wdata <= cmd.wdata;
                     last_r    <= cmd_last;
                     cmd_ready <= 1'b1;
                     sh_r      <= cmd.wdata;
                     st_r      <= ST_BIT;
                  end
               end
               ST_STOP: begin  // see (RL2) (RL15)
                  unique case (q_r)
                     2'd0: sda_r <= 1'b0;
                     2'd1: scl_r <= 1'b1;
                     2'd2: sda_r <= 1'b1;
                     default: begin st_r <= ST_IDLE; hs_r <= 1'b0; end
                  endcase
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end
   end
   // ==========================================================
   // open-drain pins: only pull low, see (RL21)
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         scl_o <= 1'b0; scl_oe_n <= 1'b1; sda_o <= 1'b0; sda_oe_n <= 1'b1; hs_active <= 1'b0;
      end else begin
         scl_o <= 1'b0; scl_oe_n <= scl_r;
         sda_o <= 1'b0; sda_oe_n <= sda_r;
         hs_active <= hs_r;
      end
   end
   // ==========================================================
   // scl high window in ST_BIT must see stable data
   property p_sda_stable;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_BIT && scl_r && $stable(scl_r)) |-> $stable(sda_r);
   endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("data moved in clock high"); // see (RL1)
   property p_stop_clears_hs;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_STOP && step && q_r == 2'd3) |=> !hs_r;
   endproperty
   a_stop_clears_hs: assert property (p_stop_clears_hs) else $error("hs kept past stop"); // see (RL15)
   property p_no_drive_high;
      @(posedge clk_sys) disable iff (!reset_n)
      (!sda_oe_n |-> !sda_o) and (!scl_oe_n |-> !scl_o);
   endproperty
   a_no_drive_high: assert property (p_no_drive_high) else $error("pin driven high"); // see (RL21)
   property p_wr_ack_release;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_ACK && !rx_phase && scl_r) |-> sda_r;
   endproperty
   a_wr_ack_release: assert property (p_wr_ack_release) else $error("data held in slave ack"); // see (RL5)
   property p_rd_ack_level;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_ACK && rx_phase && scl_r) |-> (sda_r == last_r);
   endproperty
   a_rd_ack_level: assert property (p_rd_ack_level) else $error("read ack level wrong"); // see (RL6)
   property p_rd_release;
      @(posedge clk_sys) disable iff (!reset_n)
      (st_r == ST_BIT && rx_phase && scl_r) |-> sda_r;
   endproperty
   a_rd_release: assert property (p_rd_release) else $error("data held while slave sends"); // see (RL21)
   // start: data falls while clock stays high
   sequence s_start_q2;
      (st_r == ST_START || st_r == ST_RSTRT) && step && q_r == 2'd2;
   endsequence
   sequence s_start_cond;
      scl_r && !sda_r && $past(sda_r);
   endsequence
   property p_start_cond;
      @(posedge clk_sys) disable iff (!reset_n)
      s_start_q2 |=> s_start_cond;
   endproperty
   a_start_cond: assert property (p_start_cond) else $error("start not formed"); // see (RL2)
   // stop: data rises while clock stays high
   sequence s_stop_q2;
      st_r == ST_STOP && step && q_r == 2'd2;
   endsequence
   sequence s_stop_cond;
      scl_r && sda_r && !$past(sda_r);
   endsequence
   property p_stop_cond;
      @(posedge clk_sys) disable iff (!reset_n)
      s_stop_q2 |=> s_stop_cond;
   endproperty
   a_stop_cond: assert property (p_stop_cond) else $error("stop not formed"); // see (RL2)
endmodule

// [rtl/ishp_pkg.sv]
package ishp_pkg;
   // user-side command carrier
   typedef struct packed {
      logic       is_read;
      logic [6:0] dev_addr;
      logic [7:0] reg_addr;
      logic [7:0] wdata;
   } ishp_cmd_t;
   typedef struct packed {
      logic       nack;
      logic [7:0] rdata;
   } ishp_rsp_t;
   localparam int unsigned CLK_FREQ_HZ      = 125000000;
   localparam int unsigned SCL_FREQ_HZ      = 400000;
   localparam int unsigned QUARTER_CYCLES   = CLK_FREQ_HZ / (SCL_FREQ_HZ * 4);
   localparam int unsigned HS_SCL_FREQ_HZ   = 3400000;
   localparam int unsigned HS_QUARTER_CYCLES = CLK_FREQ_HZ / (HS_SCL_FREQ_HZ * 4);
   localparam logic [7:0]  MASTER_CODE      = 8'h08;
   localparam logic        DIR_WRITE        = 1'b0;
   localparam logic        DIR_READ         = 1'b1;
endpackage

// [verification/ishp_dev_model.sv]
`timescale 1ns/1ps
// ====
// behavioural device end of the link, open drain on data
module ishp_dev_model #(
   parameter logic [3:0] PREFIX               = 4'ha, // arbitrary value
   parameter logic       FORCE_HIGH_SPEED_BIT = 1'b0
) (
   // link
   input  wire logic       scl,
   input  wire logic       sda,
   output logic            pull,
   // speed mode the device has entered
   output logic            hs,
   // strap pins
   input  wire logic       rst_n,
   input  wire logic       mode,
   input  wire logic [5:0] apins
);
   logic [7:0] mem [0:255];
   logic [7:0] sh, ra;
   logic [6:0] me;
   logic       rd;
   int         bc, ph;
   initial begin
      pull = 0;
      ph = 3;
      hs = FORCE_HIGH_SPEED_BIT;
   end
   // straps are read at each rise of rst_n, later pin changes are ignored
   always @(posedge rst_n) me = mode ? {1'b0, apins} : {PREFIX, apins[2:0]};
   // spike suppression: a start or stop counts only if the level holds
   always @(negedge sda) if (scl) begin
      #2;
      if (scl && !sda) begin
         bc = -1;
         ph = 0;
         rd = 0;
         pull = 0;
      end
   end
   always @(posedge sda) if (scl) begin
      #2;
      if (scl && sda) begin
         ph = 3;
         hs = FORCE_HIGH_SPEED_BIT;
      end
   end
   always @(posedge scl) begin
      if (bc < 8 && !(rd && ph == 2)) sh = {sh[6:0], sda};
      if (bc == 8 && rd && ph == 2 && sda) ph = 3;
   end
   // only pulls low or releases; changes after the clock falls, and releases at a start
   always @(negedge scl) begin
      bc = (bc == 8) ? 0 : bc + 1;
      pull = 0;
      if (bc == 8 && ph == 0) begin
         if (sh[7:1] == me) begin
            pull = 1;
            rd = sh[0];
            ph = sh[0] ? 2 : 1;
         end else begin
            hs = FORCE_HIGH_SPEED_BIT || (sh[7:3] == 5'h01);
            ph = 3;
         end
      end else if (bc == 8 && ph == 1) begin
         ra = sh;
         pull = 1;
         ph = 2;
      end else if (bc == 8 && ph == 2 && !rd) begin
         mem[ra] = sh;
         pull = 1;
      end
      if (rd && ph == 2 && bc < 8) begin
         if (bc == 0) sh = mem[ra];
         pull = !sh[7 - bc];
      end
   end
endmodule

// [verification/tb_ishp_host.sv]
`timescale 1ns/1ps
// ====
// bench: user port stimulus, shadow registers hold the expectations
module tb_ishp_host;
   localparam logic [3:0] PFX = 4'ha; // arbitrary value
   logic                clk_sys, reset_n, cmd_valid, cmd_last, use_hs, mode, hs_seen;
   logic [5:0]          apins;
   logic [6:0]          me;
   logic [7:0]          ra;
   logic [7:0]          shadow [0:255];
   ishp_pkg::ishp_cmd_t cmd;
   ishp_pkg::ishp_rsp_t rsp;
   logic                cmd_ready, rsp_valid, hs_active, scl_o, scl_oe_n, sda_o, sda_oe_n, pull, dev_hs;
   int                  miscompares, checks_done, seed, n;
   wire                 scl = scl_oe_n ? 1'b1 : scl_o;
   wire                 sda = (sda_oe_n ? 1'b1 : sda_o) & !pull;
   ishp_host dut (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_last(cmd_last), .use_hs(use_hs), .cmd_ready(cmd_ready), .rsp(rsp), .rsp_valid(rsp_valid),
      .hs_active(hs_active), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   ishp_dev_model #(.PREFIX(PFX)) dev (.scl(scl), .sda(sda), .pull(pull), .hs(dev_hs), .rst_n(reset_n),
      .mode(mode), .apins(apins));
   initial begin
      clk_sys = 0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #760000;
      miscompares++;
      print_verdict;
   end
   task automatic chk(logic [9:0] got, logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // all sampling at the falling edge, where registered outputs are settled
   task automatic byte_op(logic rd, logic [6:0] da, logic [7:0] r, logic [7:0] wd, logic last, logic [8:0] exp);
      int k;
      cmd = '{rd, da, r, wd};
      cmd_last = last;
      cmd_valid = 1;
      for (k = 0; k < 40000 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
      cmd_valid = 0;
      for (k = 0; k < 40000 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
      hs_seen = hs_active;
      chk({rsp_valid, rsp.nack, rd ? rsp.rdata : 8'h00}, {1'b1, exp});
      @(negedge clk_sys);
   endtask
   task automatic wr(logic [7:0] r, int cnt);
      logic [7:0] d;
      for (int i = 0; i < cnt; i++) begin
         d = 8'($random(seed));
         byte_op(1'b0, me, r, d, i == cnt - 1, 9'h000);
         shadow[r] = d;
      end
      $display("write frame %h done", r);
   endtask
   task automatic rdf(logic [7:0] r, int cnt);
      for (int i = 0; i < cnt; i++) byte_op(1'b1, me, r, 8'h00, i == cnt - 1, {1'b0, shadow[r]});
      $display("read frame %h done", r);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      seed = 40118;
      miscompares = 0;
      checks_done = 0;
      {reset_n, cmd, cmd_valid, cmd_last, use_hs} = '0;
      mode = 1;
      apins = 6'($random(seed));
      if (apins == 6'h04) apins = 6'h05; // 0000100 would alias the master code
      repeat (4) @(negedge clk_sys);
      reset_n = 1;
      me = {1'b0, apins};
      @(negedge clk_sys);
      apins = ~apins;
      chk({9'h0, hs_active}, 10'h0);
      wr(8'h0a, 3);
      rdf(8'h0a, 3);
      // one random register keeps the run within its cycle budget
      repeat (1) begin
         ra = 8'($random(seed));
         wr(ra, 1);
         rdf(ra, 2);
      end
      byte_op(1'b0, me ^ 7'h01, 8'h01, 8'h00, 1'b1, 9'h100);
      $display("address mismatch done");
      use_hs = 1;
      wr(8'h33, 2);
      chk({9'h0, hs_seen}, 10'h1);
      chk({9'h0, dev_hs}, 10'h1);
      rdf(8'h33, 1);
      use_hs = 0;
      for (n = 0; n < 3000 && hs_active !== 1'b0; n++) @(negedge clk_sys);
      chk({9'h0, hs_active}, 10'h0);
      chk({9'h0, dev_hs}, 10'h0);
      // second reset, now with the prefix addressing mode
      reset_n = 0;
      mode = 0;
      apins = 6'($random(seed));
      repeat (4) @(negedge clk_sys);
      reset_n = 1;
      me = {PFX, apins[2:0]};
      @(negedge clk_sys);
      apins = ~apins;
      chk({9'h0, hs_active}, 10'h0);
      wr(8'h5a, 1);
      print_verdict;
   end
endmodule
